// >>> ioc_input_capture_latches.sv
// Input capture latches and fast-capture stages of one I/O block
module ioc_input_capture_latches #(
    parameter int unsigned WIDTH         = ioc_pkg::DATA_W,
    parameter bit          SET_RESET_LOW = ioc_pkg::SET_RESET_LOW_DEF
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               global_set_reset_i,
    // Transparent latch family
    input  wire logic [WIDTH-1:0]   input_pad_i,
    input  wire ioc_pkg::ioc_gate_t clr_low_gate_i,
    input  wire ioc_pkg::ioc_gate_t pre_high_gate_i,
    input  wire ioc_pkg::ioc_gate_t pre_low_gate_i,
    // Fast capture family
    input  wire logic [WIDTH-1:0]   bidir_pad_i,
    input  wire logic               fast_gate_i,
    input  wire logic               int_clk_i,
    input  wire logic               clk_en_i,
    input  wire ioc_pkg::ioc_gate_t fast_high_gate_i,
    input  wire ioc_pkg::ioc_gate_t fast_low_gate_i,
    // Latch and flop outputs
    output logic [WIDTH-1:0]        clear_latch_low_gate_o,
    output logic [WIDTH-1:0]        preset_latch_high_gate_o,
    output logic [WIDTH-1:0]        preset_falling_flop_o,
    output logic [WIDTH-1:0]        preset_latch_low_gate_o,
    output logic [WIDTH-1:0]        preset_rising_flop_o,
    // Fast capture outputs
    output logic [WIDTH-1:0]        fast_capture_flop_clear_o,
    output logic [WIDTH-1:0]        fast_capture_flop_preset_o,
    output logic [WIDTH-1:0]        fast_capture_latch_high_o,
    output logic [WIDTH-1:0]        fast_capture_latch_low_o,
    output logic [WIDTH-1:0]        captured_node_o
);

    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    localparam logic [WIDTH-1:0] ALL_CLR = {WIDTH{ioc_pkg::CLEAR_VAL}};
    localparam logic [WIDTH-1:0] ALL_PRE = {WIDTH{ioc_pkg::PRESET_VAL}};

    // Set/reset polarity and the combined init
    wire logic set_reset_act;
    wire logic init_n;
    assign set_reset_act = SET_RESET_LOW ? ~global_set_reset_i : global_set_reset_i;
    // Same init as power-up; set/reset must be glitch free, it is an async reset
    assign init_n        = rst_n_i & ~set_reset_act;

    // Sampled gate history for edge detection
    logic pre_high_g_q;
    logic pre_low_g_q;
    logic int_clk_q;

    // Rise detectors start high: a level already high at release is no edge
    always_ff @(posedge clk_i or negedge init_n) begin
        if (!init_n) begin
            pre_high_g_q <= 1'h0;
            pre_low_g_q  <= 1'h1;
            int_clk_q    <= 1'h1;
        end else begin
            pre_high_g_q <= pre_high_gate_i.gate;
            pre_low_g_q  <= pre_low_gate_i.gate;
            int_clk_q    <= int_clk_i;
        end
    end

    // Transparency and edge decodes
    wire logic clr_open;
    wire logic pre_high_open;
    wire logic pre_low_open;
    wire logic pre_high_fall;
    wire logic pre_low_rise;
    wire logic int_clk_rise;
    wire logic fast_open;
    wire logic fast_high_open;
    wire logic fast_low_open;
    assign clr_open       = clr_low_gate_i.enable & ~clr_low_gate_i.gate;
    assign pre_high_open  = pre_high_gate_i.enable & pre_high_gate_i.gate;
    assign pre_low_open   = pre_low_gate_i.enable & ~pre_low_gate_i.gate;
    assign pre_high_fall  = pre_high_g_q & ~pre_high_gate_i.gate;
    assign pre_low_rise   = ~pre_low_g_q & pre_low_gate_i.gate;
    assign int_clk_rise   = ~int_clk_q & int_clk_i;
    // Output-clock gating lets capture run apart from the input clock
    assign fast_open      = ~fast_gate_i;
    assign fast_high_open = fast_high_gate_i.enable & fast_high_gate_i.gate;
    assign fast_low_open  = fast_low_gate_i.enable & ~fast_low_gate_i.gate;

    // Storage state
    logic [WIDTH-1:0] clr_lat_q;
    logic [WIDTH-1:0] clr_lat_d;
    logic [WIDTH-1:0] pre_hi_q;
    logic [WIDTH-1:0] pre_hi_d;
    logic [WIDTH-1:0] pre_fall_q;
    logic [WIDTH-1:0] pre_fall_d;
    logic [WIDTH-1:0] pre_lo_q;
    logic [WIDTH-1:0] pre_lo_d;
    logic [WIDTH-1:0] pre_rise_q;
    logic [WIDTH-1:0] pre_rise_d;
    logic [WIDTH-1:0] node_clr_q;
    logic [WIDTH-1:0] node_clr_d;
    logic [WIDTH-1:0] node_pre_q;
    logic [WIDTH-1:0] node_pre_d;
    logic [WIDTH-1:0] ff_clr_q;
    logic [WIDTH-1:0] ff_clr_d;
    logic [WIDTH-1:0] ff_pre_q;
    logic [WIDTH-1:0] ff_pre_d;
    logic [WIDTH-1:0] fl_hi_q;
    logic [WIDTH-1:0] fl_hi_d;
    logic [WIDTH-1:0] fl_lo_q;
    logic [WIDTH-1:0] fl_lo_d;

    // Transparent latches; outputs lag the pad by one clock
    assign clr_lat_d  = clr_open ? input_pad_i : clr_lat_q;
    assign pre_hi_d   = pre_high_open ? input_pad_i : pre_hi_q;
    assign pre_lo_d   = pre_low_open ? input_pad_i : pre_lo_q;
    // Slaves read the stored master value; each edge output keeps its own store
    assign pre_fall_d = pre_high_fall ? pre_hi_q : pre_fall_q;
    assign pre_rise_d = pre_low_rise ? pre_lo_q : pre_rise_q;

    // Fast stage straight off the pad; node value passes through when open
    assign node_clr_d = fast_open ? bidir_pad_i : node_clr_q;
    assign node_pre_d = fast_open ? bidir_pad_i : node_pre_q;
    assign ff_clr_d   = (clk_en_i & int_clk_rise) ? node_clr_d : ff_clr_q;
    assign ff_pre_d   = (clk_en_i & int_clk_rise) ? node_pre_d : ff_pre_q;
    assign fl_hi_d    = fast_high_open ? node_clr_d : fl_hi_q;
    assign fl_lo_d    = fast_low_open ? node_clr_d : fl_lo_q;

    // Clear-type elements
    always_ff @(posedge clk_i or negedge init_n) begin
        if (!init_n) begin
            clr_lat_q  <= ALL_CLR;
            node_clr_q <= ALL_CLR;
            ff_clr_q   <= ALL_CLR;
            fl_hi_q    <= ALL_CLR;
            fl_lo_q    <= ALL_CLR;
        end else begin
            clr_lat_q  <= clr_lat_d;
            node_clr_q <= node_clr_d;
            ff_clr_q   <= ff_clr_d;
            fl_hi_q    <= fl_hi_d;
            fl_lo_q    <= fl_lo_d;
        end
    end

    // Preset-type elements
    always_ff @(posedge clk_i or negedge init_n) begin
        if (!init_n) begin
            pre_hi_q   <= ALL_PRE;
            pre_fall_q <= ALL_PRE;
            pre_lo_q   <= ALL_PRE;
            pre_rise_q <= ALL_PRE;
            node_pre_q <= ALL_PRE;
            ff_pre_q   <= ALL_PRE;
        end else begin
            pre_hi_q   <= pre_hi_d;
            pre_fall_q <= pre_fall_d;
            pre_lo_q   <= pre_lo_d;
            pre_rise_q <= pre_rise_d;
            node_pre_q <= node_pre_d;
            ff_pre_q   <= ff_pre_d;
        end
    end

    assign clear_latch_low_gate_o     = clr_lat_q;
    assign preset_latch_high_gate_o   = pre_hi_q;
    assign preset_falling_flop_o      = pre_fall_q;
    assign preset_latch_low_gate_o    = pre_lo_q;
    assign preset_rising_flop_o       = pre_rise_q;
    assign fast_capture_flop_clear_o  = ff_clr_q;
    assign fast_capture_flop_preset_o = ff_pre_q;
    assign fast_capture_latch_high_o  = fl_hi_q;
    assign fast_capture_latch_low_o   = fl_lo_q;
    assign captured_node_o            = node_clr_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!init_n);

    chk_low_latch_follow : assert property (
        clr_open |=> clear_latch_low_gate_o == $past(input_pad_i))
        else $error("low-gate clear latch did not follow pad");

    chk_high_latch_hold : assert property (
        (pre_high_gate_i.enable && !pre_high_gate_i.gate) [*2]
            |-> $stable(preset_latch_high_gate_o))
        else $error("high-gate preset latch changed while closed");

    chk_enable_low_hold : assert property (
        !clr_low_gate_i.enable && !pre_low_gate_i.enable
            |=> $stable(clear_latch_low_gate_o) && $stable(preset_latch_low_gate_o))
        else $error("latch changed with gate enable low");

    chk_falling_slave : assert property (
        pre_high_g_q && !pre_high_gate_i.gate
            |=> preset_falling_flop_o == $past(preset_latch_high_gate_o))
        else $error("falling flop missed master value");

    chk_rising_slave : assert property (
        !pre_low_g_q && pre_low_gate_i.gate
            |=> preset_rising_flop_o == $past(preset_latch_low_gate_o))
        else $error("rising flop missed master value");

    chk_node_hold : assert property (
        fast_gate_i ##1 fast_gate_i |-> $stable(captured_node_o))
        else $error("captured node moved while fast gate high");

    chk_fast_flop_xfer : assert property (
        clk_en_i && !int_clk_q && int_clk_i && !fast_gate_i
            |=> fast_capture_flop_clear_o == $past(bidir_pad_i)
                && fast_capture_flop_preset_o == $past(bidir_pad_i))
        else $error("fast flop did not take the node value");

    chk_fast_flop_idle : assert property (
        !clk_en_i |=> $stable(fast_capture_flop_clear_o))
        else $error("fast flop changed without clock enable");

    chk_fast_latch_high : assert property (
        fast_high_open && fast_gate_i
            |=> fast_capture_latch_high_o == $past(captured_node_o))
        else $error("true-gate fast latch did not show node");

    chk_fast_latch_low : assert property (
        !fast_low_gate_i.enable || fast_low_gate_i.gate
            |=> $stable(fast_capture_latch_low_o))
        else $error("inverted-gate fast latch changed while closed");

    chk_reset_values : assert property (
        @(posedge clk_i) disable iff (1'b0)
        !init_n |-> clear_latch_low_gate_o == ALL_CLR
            && preset_latch_high_gate_o == ALL_PRE
            && fast_capture_flop_preset_o == ALL_PRE
            && fast_capture_flop_clear_o == ALL_CLR)
        else $error("init values wrong during set/reset");

    chk_high_latch_load : assert property (
        pre_high_open |=> preset_latch_high_gate_o == $past(input_pad_i))
        else $error("high-gate preset latch did not follow pad");

    chk_low_preset_load : assert property (
        pre_low_open |=> preset_latch_low_gate_o == $past(input_pad_i))
        else $error("low-gate preset latch did not follow pad");

    chk_low_latch_hold : assert property (
        clr_low_gate_i.enable && clr_low_gate_i.gate |=> $stable(clear_latch_low_gate_o))
        else $error("low-gate clear latch changed while closed");

    chk_node_load : assert property (
        !fast_gate_i |=> captured_node_o == $past(bidir_pad_i))
        else $error("captured node did not follow pad while open");

    chk_fast_latch_show : assert property (
        fast_low_open && fast_gate_i
            |=> fast_capture_latch_low_o == $past(captured_node_o))
        else $error("inverted-gate fast latch did not show node");

    chk_fast_high_closed : assert property (
        !fast_high_gate_i.enable |=> $stable(fast_capture_latch_high_o))
        else $error("true-gate fast latch changed with enable low");

    chk_preset_flop_idle : assert property (
        !clk_en_i |=> $stable(fast_capture_flop_preset_o))
        else $error("preset fast flop changed without clock enable");

    chk_flop_no_rise : assert property (
        !int_clk_rise
            |=> $stable(fast_capture_flop_clear_o) && $stable(fast_capture_flop_preset_o))
        else $error("fast flop changed without internal clock rise");

    chk_fast_retime : assert property (
        clk_en_i && int_clk_rise && fast_gate_i
            |=> fast_capture_flop_clear_o == $past(captured_node_o))
        else $error("fast flop did not re-time the held node");

    chk_clear_init : assert property (
        @(posedge clk_i) disable iff (1'b0)
        !init_n |-> captured_node_o == ALL_CLR
            && fast_capture_latch_high_o == ALL_CLR
            && fast_capture_latch_low_o == ALL_CLR)
        else $error("clear-type fast stage wrong during set/reset");

    chk_preset_init : assert property (
        @(posedge clk_i) disable iff (1'b0)
        !init_n |-> preset_falling_flop_o == ALL_PRE
            && preset_latch_low_gate_o == ALL_PRE
            && preset_rising_flop_o == ALL_PRE)
        else $error("preset latches wrong during set/reset");

    chk_set_reset_pol : assert property (
        @(posedge clk_i) disable iff (1'b0)
        set_reset_act |-> clear_latch_low_gate_o == ALL_CLR
            && preset_latch_high_gate_o == ALL_PRE)
        else $error("set/reset polarity did not start init");

endmodule : ioc_input_capture_latches

// >>> ioc_pad_model.sv
// External pin model driving both pad inputs of the capture block
module ioc_pad_model (
    // Clock
    input  wire logic       clk_i,
    // Requested pin levels
    input  wire logic       drive_i,
    input  wire logic [1:0] level_i,
    // Pads
    output logic            input_pad_o,
    output logic            bidir_pad_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       drive_s;
    logic [1:0] level_s;

    initial begin
        input_pad_o = 1'h0;
        bidir_pad_o = 1'h0;
    end

    // Pin levels sampled at the clock edge and put on the pads 5 ns later
    always @(posedge clk_i) begin
        drive_s = drive_i;
        level_s = level_i;
        #5;
        if (drive_s) begin
            input_pad_o = level_s[0];
            bidir_pad_o = level_s[1];
        end else begin
            // Released pin must not look like a held copy of the last value
            input_pad_o = ~input_pad_o;
            bidir_pad_o = ~bidir_pad_o;
        end
    end
endmodule : ioc_pad_model

// >>> ioc_pkg.sv
// Shared constants and carrier types for the I/O input capture latches
package ioc_pkg;

    // Default data width of each storage element
    localparam int unsigned DATA_W = 1;

    // Power-up values of the two storage families
    localparam logic CLEAR_VAL  = 1'h0;
    localparam logic PRESET_VAL = 1'h1;

    // Global set/reset polarity: 0 active high, 1 active low
    localparam logic SET_RESET_LOW_DEF = 1'h0;

    // Gate pair of one transparent element
    typedef struct packed {
        logic enable;
        logic gate;
    } ioc_gate_t;

endpackage : ioc_pkg

// >>> tb_ioc_input_capture_latches.sv
// Self-checking bench for the input capture latches against a reference model
module tb_ioc_input_capture_latches;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk_i = 1'h0;
    logic               rst_n_i;
    logic               global_set_reset;
    logic               int_clk, clk_en, fast_gate, drive;
    logic [1:0]         level;
    logic               input_pad, bidir_pad;
    ioc_pkg::ioc_gate_t g_cl, g_ph, g_pl, g_fh, g_fl;
    wire logic [9:0]    dut_o;
    logic [9:0]         mdl;
    logic               fpn, nd, pn, ph_p, pl_p, ic_p;
    logic [31:0]        r;
    integer             seed;
    int                 errors, compares;

    ioc_pad_model u_ioc_pad_model (
        .clk_i(clk_i), .drive_i(drive), .level_i(level),
        .input_pad_o(input_pad), .bidir_pad_o(bidir_pad)
    );

    ioc_input_capture_latches u_ioc_input_capture_latches (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .global_set_reset_i(global_set_reset),
        .input_pad_i(input_pad), .clr_low_gate_i(g_cl), .pre_high_gate_i(g_ph),
        .pre_low_gate_i(g_pl), .bidir_pad_i(bidir_pad), .fast_gate_i(fast_gate),
        .int_clk_i(int_clk), .clk_en_i(clk_en), .fast_high_gate_i(g_fh),
        .fast_low_gate_i(g_fl), .clear_latch_low_gate_o(dut_o[0]),
        .preset_latch_high_gate_o(dut_o[1]), .preset_falling_flop_o(dut_o[2]),
        .preset_latch_low_gate_o(dut_o[3]), .preset_rising_flop_o(dut_o[4]),
        .fast_capture_flop_clear_o(dut_o[5]), .fast_capture_flop_preset_o(dut_o[6]),
        .fast_capture_latch_high_o(dut_o[7]), .fast_capture_latch_low_o(dut_o[8]),
        .captured_node_o(dut_o[9])
    );

    // Start value comes from the declaration, so time zero shows no edge
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // Reference step: every element samples its inputs at the clock edge
    always @(posedge clk_i) begin
        if (!rst_n_i || global_set_reset) begin
            mdl = 10'h05E;
            fpn = 1'h1;
            {ph_p, pl_p, ic_p} = 3'h3;
        end else begin
            nd = fast_gate ? mdl[9] : bidir_pad;
            pn = fast_gate ? fpn : bidir_pad;
            if (ph_p && !g_ph.gate) mdl[2] = mdl[1];
            if (!pl_p && g_pl.gate) mdl[4] = mdl[3];
            if (!ic_p && int_clk && clk_en) mdl[6:5] = {pn, nd};
            if (g_cl.enable && !g_cl.gate) mdl[0] = input_pad;
            if (g_ph.enable && g_ph.gate) mdl[1] = input_pad;
            if (g_pl.enable && !g_pl.gate) mdl[3] = input_pad;
            if (g_fh.enable && g_fh.gate) mdl[7] = nd;
            if (g_fl.enable && !g_fl.gate) mdl[8] = nd;
            mdl[9] = nd;
            fpn = pn;
            {ph_p, pl_p, ic_p} = {g_ph.gate, g_pl.gate, int_clk};
        end
    end

    // Reset acts without a clock edge, so the model follows it here too
    always @(negedge clk_i) begin
        if (!rst_n_i || global_set_reset) mdl = 10'h05E;
        check("outputs", dut_o, mdl);
    end

    task automatic run(input int n, input int gsr_rate, input string name);
        repeat (n) begin
            @(posedge clk_i);
            #5;
            r = $random(seed);
            {int_clk, clk_en, fast_gate, drive, level} = r[5:0];
            {g_cl, g_ph, g_pl, g_fh, g_fl} = r[15:6];
            global_set_reset = (gsr_rate != 0) && (r[19:16] == 4'h0);
        end
        $display("test %s done, mismatches %0d", name, errors);
    endtask : run

    initial begin
        seed = 92;
        errors = 0;
        compares = 0;
        rst_n_i = 1'h1;
        global_set_reset = 1'h0;
        {int_clk, clk_en, fast_gate, drive, level} = 6'h00;
        {g_cl, g_ph, g_pl, g_fh, g_fl} = 10'h000;
        // A real falling edge, so the async reset fires without racing time zero
        #5 rst_n_i = 1'h0;
        repeat (3) @(posedge clk_i);
        #5 rst_n_i = 1'h1;
        run(2000, 0, "random_capture");
        run(2000, 1, "global_set_reset");
        @(posedge clk_i);
        #5 rst_n_i = 1'h0;
        repeat (2) @(posedge clk_i);
        #5 rst_n_i = 1'h1;
        run(500, 0, "second_reset");
        global_set_reset = 1'h0;
        wrap_up();
    end

    // Run needs about 4500 cycles; cut off well beyond that
    initial begin
        #500000;
        errors++;
        wrap_up();
    end
endmodule : tb_ioc_input_capture_latches
